// *** nand_host_pkg.sv ***
// package: commands, timing and carrier types for the nand status/column host controller
package nand_host_pkg;
   localparam logic [7:0] CMD_STATUS       = 8'h70;
   localparam logic [7:0] CMD_ADDR_STATUS  = 8'h78;
   localparam logic [7:0] CMD_READ_MODE    = 8'h00;
   localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_END = 8'hE0;
   localparam logic [7:0] CMD_RAND_IN      = 8'h85;
   localparam int CLK_NS               = 10;
   localparam int CMD_TO_OUTPUT_NS     = 60;
   localparam int ADDR_TO_DATA_NS      = 70;
   localparam int STROBE_NS            = 20;
   localparam int CMD_TO_OUTPUT_CYC    = (CMD_TO_OUTPUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_TO_DATA_CYC     = (ADDR_TO_DATA_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC           = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAIT_W               = 8;

   // user operation codes
   typedef enum logic [2:0] {
      OP_STATUS, OP_ADDR_STATUS, OP_READ_MODE, OP_RAND_OUT,
      OP_RAND_IN, OP_REDIRECT, OP_READ_BYTE, OP_WRITE_BYTE
   } op_t;

   typedef struct packed {
      op_t         op;
      logic [15:0] column;
      logic [23:0] row;
      logic [7:0]  wdata;
   } req_t;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic [7:0] io_out;
      logic       io_oe;
   } pins_t;
endpackage

// *** nand_status_column_cmds.sv ***
// host controller issuing status and column-address command sequences to a nand target
`timescale 1ns/100ps
module nand_status_column_cmds #(
   parameter int CMD_TO_OUTPUT_CYCLES = nand_host_pkg::CMD_TO_OUTPUT_CYC,
   parameter int ADDR_TO_DATA_CYCLES  = nand_host_pkg::ADDR_TO_DATA_CYC,
   parameter int STROBE_CYCLES        = nand_host_pkg::STROBE_CYC
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 req_valid,
   output      logic                 req_ready,
   input  wire nand_host_pkg::req_t  req,
   input  wire logic                 power_on_reset_busy,
   input  wire logic                 otp_mode,
   input  wire logic                 multi_die_active,
   output      logic                 refused,
   output      logic                 rsp_valid,
   output      logic [7:0]           rsp_data,
   output      nand_host_pkg::pins_t pins,
   input  wire logic [7:0]           io_in
);
   typedef enum {S_IDLE, S_CMD, S_ADDR, S_CMD2, S_WAIT, S_READ, S_WRITE} state_t;

   localparam int WAIT_W_L = nand_host_pkg::WAIT_W;
   localparam logic [WAIT_W_L-1:0] ONE = WAIT_W_L'(1);

   state_t                 state, next_state;
   nand_host_pkg::req_t    cur, next_cur;
   logic [2:0]             cycle_idx, next_cycle_idx;
   logic [2:0]             addr_total, next_addr_total;
   logic [WAIT_W_L-1:0]    count, next_count;
   logic                   phase, next_phase;
   nand_host_pkg::pins_t   next_pins;
   logic                   next_rsp_valid, next_refused;
   logic [7:0]             next_rsp_data;
   logic [7:0]             addr_byte;
   logic [7:0]             first_cmd;
   logic                   forbidden;
   logic                   die_picked, next_die_picked;

   assign req_ready = (state == S_IDLE);

   // forbidden orders are refused at the user port
   always_comb begin
      forbidden = 1'b0;
      if (req.op == nand_host_pkg::OP_ADDR_STATUS && (power_on_reset_busy || otp_mode))
         forbidden = 1'b1;
      if (req.op == nand_host_pkg::OP_STATUS && multi_die_active)
         forbidden = 1'b1;
      if (req.op == nand_host_pkg::OP_RAND_OUT && multi_die_active && !die_picked)
         forbidden = 1'b1;
   end

   always_comb begin
      case (cur.op)
         nand_host_pkg::OP_STATUS:      first_cmd = nand_host_pkg::CMD_STATUS;
         nand_host_pkg::OP_ADDR_STATUS: first_cmd = nand_host_pkg::CMD_ADDR_STATUS;
         nand_host_pkg::OP_READ_MODE:   first_cmd = nand_host_pkg::CMD_READ_MODE;
         nand_host_pkg::OP_RAND_OUT:    first_cmd = nand_host_pkg::CMD_RAND_OUT;
         default:                       first_cmd = nand_host_pkg::CMD_RAND_IN;
      endcase
   end

   // column cycles low byte first, then row cycles low byte first; addressed status sends its three row cycles only
   always_comb begin
      case (cycle_idx)
         3'd0:    addr_byte = (cur.op == nand_host_pkg::OP_ADDR_STATUS) ? cur.row[7:0]
                                                                         : cur.column[7:0];
         3'd1:    addr_byte = (cur.op == nand_host_pkg::OP_ADDR_STATUS) ? cur.row[15:8]
                                                                         : cur.column[15:8];
         3'd2:    addr_byte = (cur.op == nand_host_pkg::OP_ADDR_STATUS) ? cur.row[23:16]
                                                                         : cur.row[7:0];
         3'd3:    addr_byte = cur.row[15:8];
         default: addr_byte = cur.row[23:16];
      endcase
   end

   always_comb begin
      next_state      = state;
      next_cur        = cur;
      next_cycle_idx  = cycle_idx;
      next_addr_total = addr_total;
      next_count      = count;
      next_phase      = phase;
      next_pins       = pins;
      next_rsp_valid  = 1'b0;
      next_rsp_data   = rsp_data;
      next_refused    = 1'b0;
      next_die_picked = die_picked && multi_die_active;
      case (state)
         S_IDLE: begin
            next_pins.we_n  = 1'b1;
            next_pins.re_n  = 1'b1;
            next_pins.cle   = 1'b0;
            next_pins.ale   = 1'b0;
            next_pins.io_oe = 1'b0;
            if (req_valid && forbidden) begin
               next_refused = 1'b1;
            end else if (req_valid) begin
               next_cur       = req;
               next_cycle_idx = 3'd0;
               next_phase     = 1'b0;
               next_count     = WAIT_W_L'(STROBE_CYCLES);
               next_pins.ce_n = 1'b0;
               if (req.op == nand_host_pkg::OP_ADDR_STATUS)
                  next_die_picked = 1'b1;
               case (req.op)
                  nand_host_pkg::OP_READ_BYTE:  next_state = S_READ;
                  nand_host_pkg::OP_WRITE_BYTE: next_state = S_WRITE;
                  default:                      next_state = S_CMD;
               endcase
               case (req.op)
                  nand_host_pkg::OP_ADDR_STATUS: next_addr_total = 3'd3;
                  nand_host_pkg::OP_REDIRECT:    next_addr_total = 3'd5;
                  nand_host_pkg::OP_RAND_OUT,
                  nand_host_pkg::OP_RAND_IN:     next_addr_total = 3'd2;
                  default:                       next_addr_total = 3'd0;
               endcase
            end
         end
         S_CMD, S_CMD2, S_ADDR, S_WRITE: begin
            // each bus write: we low for strobe time, then high for strobe time
            next_pins.cle    = (state == S_CMD) || (state == S_CMD2);
            next_pins.ale    = (state == S_ADDR);
            next_pins.io_oe  = 1'b1;
            next_pins.io_out = (state == S_CMD)  ? first_cmd :
                               (state == S_CMD2) ? nand_host_pkg::CMD_RAND_OUT_END :
                               (state == S_ADDR) ? addr_byte : cur.wdata;
            next_pins.we_n   = phase;
            if (count > ONE) begin
               next_count = count - ONE;
            end else begin
               next_count = WAIT_W_L'(STROBE_CYCLES);
               next_phase = ~phase;
               if (phase) begin
                  next_phase = 1'b0;
                  if (state == S_CMD && addr_total != 3'd0) begin
                     next_state = S_ADDR;
                  end else if (state == S_ADDR && cycle_idx + 3'd1 < addr_total) begin
                     next_cycle_idx = cycle_idx + 3'd1;
                  end else if (state == S_ADDR && cur.op == nand_host_pkg::OP_RAND_OUT) begin
                     next_state = S_CMD2;
                  end else begin
                     next_state = S_WAIT;
                     next_count = ONE;
                     if (cur.op == nand_host_pkg::OP_RAND_IN || cur.op == nand_host_pkg::OP_REDIRECT)
                        next_count = WAIT_W_L'(ADDR_TO_DATA_CYCLES);
                     else if (cur.op != nand_host_pkg::OP_WRITE_BYTE)
                        next_count = WAIT_W_L'(CMD_TO_OUTPUT_CYCLES);
                  end
               end
            end
         end
         S_READ: begin
            // read strobe; status or cache byte sampled at re rising
            next_pins.io_oe = 1'b0;
            next_pins.re_n  = phase;
            // io_in is valid only while re is already low on the pins
            if (!pins.re_n)
               next_rsp_data = io_in;
            if (count > ONE) begin
               next_count = count - ONE;
            end else begin
               next_count = WAIT_W_L'(STROBE_CYCLES);
               next_phase = ~phase;
               if (phase) begin
                  next_rsp_valid = 1'b1;
                  next_state     = S_IDLE;
               end
            end
         end
         S_WAIT: begin
            next_pins.cle   = 1'b0;
            next_pins.ale   = 1'b0;
            next_pins.io_oe = 1'b0;
            next_pins.we_n  = 1'b1;
            if (count > ONE) begin
               next_count = count - ONE;
            end else begin
               next_rsp_valid = 1'b1;
               next_state     = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state      <= S_IDLE;
         cur        <= '0;
         cycle_idx  <= 3'd0;
         addr_total <= 3'd0;
         count      <= '0;
         phase      <= 1'b0;
         pins       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                         io_out: 8'h00, io_oe: 1'b0};
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
         refused    <= 1'b0;
         die_picked <= 1'b0;
      end else begin
         state      <= next_state;
         cur        <= next_cur;
         cycle_idx  <= next_cycle_idx;
         addr_total <= next_addr_total;
         count      <= next_count;
         phase      <= next_phase;
         pins       <= next_pins;
         rsp_valid  <= next_rsp_valid;
         rsp_data   <= next_rsp_data;
         refused    <= next_refused;
         die_picked <= next_die_picked;
      end
   end

   a_no_status_multi: assert property (@(posedge core_clk) disable iff (reset)
      (state == S_IDLE && req_valid && req.op == nand_host_pkg::OP_STATUS && multi_die_active)
      |=> refused && state == S_IDLE)
      else $error("plain status issued during multi-die activity");
   a_no_addr_status: assert property (@(posedge core_clk) disable iff (reset)
      (state == S_IDLE && req_valid && req.op == nand_host_pkg::OP_ADDR_STATUS
       && (power_on_reset_busy || otp_mode)) |=> refused)
      else $error("addressed status issued during reset or otp");
   a_rand_out_picked: assert property (@(posedge core_clk) disable iff (reset)
      (state == S_IDLE && req_valid && req.op == nand_host_pkg::OP_RAND_OUT
       && multi_die_active && !die_picked) |=> refused && state == S_IDLE)
      else $error("random output issued before die selection");
   a_wait_after_addr: assert property (@(posedge core_clk) disable iff (reset)
      (state == S_ADDR && next_state == S_WAIT
       && (cur.op == nand_host_pkg::OP_RAND_IN || cur.op == nand_host_pkg::OP_REDIRECT))
      |=> count == WAIT_W_L'(ADDR_TO_DATA_CYCLES))
      else $error("address-to-data wait not loaded");
   a_end_cmd_after: assert property (@(posedge core_clk) disable iff (reset)
      $rose(pins.cle) && pins.io_out == nand_host_pkg::CMD_RAND_OUT_END
      |-> $past(pins.ale, 2) && cur.op == nand_host_pkg::OP_RAND_OUT)
      else $error("e0 cycle not preceded by column cycles");
   a_addr_count: assert property (@(posedge core_clk) disable iff (reset)
      state == S_ADDR |-> cycle_idx < addr_total)
      else $error("too many address cycles");
   a_io_released: assert property (@(posedge core_clk) disable iff (reset)
      state == S_READ |=> !pins.io_oe)
      else $error("host drives io while reading");
endmodule

// *** nand_die_model.sv ***
// behavioural pair of nand dies answering status and column-address commands
`timescale 1ns/100ps
module nand_die_model #(
   parameter logic [7:0] STATUS_DIE0 = 8'hE0,
   parameter logic [7:0] STATUS_DIE1 = 8'hC1
) (
   input  wire nand_host_pkg::pins_t pins,
   output      logic [7:0]           io_in
);
   logic [7:0]  cache [0:4351];
   logic [7:0]  cmd = 8'hFF;
   logic [7:0]  addr_q [$];
   logic [15:0] col = '0;
   logic [23:0] dest_row = '0;
   logic        sel_die = 1'b0;
   logic        status_mode = 1'b0;
   logic [7:0]  last = 8'hA5;
   wire  [7:0]  stat = sel_die ? STATUS_DIE1 : STATUS_DIE0;
   // status follows the die live while re is low; released bus shows inverse of last byte
   assign io_in = (!pins.ce_n && !pins.re_n) ? (status_mode ? stat : cache[col % 4352]) : ~last;
   initial begin
      for (int i = 0; i < 4352; i++) cache[i] = 8'(i) ^ 8'h3C;
   end
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.cle) begin
         if (pins.io_out == 8'hE0 && cmd == 8'h05 && addr_q.size() == 2) begin
            col = {addr_q[1], addr_q[0]};
            status_mode = 1'b0;
         end
         if (pins.io_out == 8'h70) status_mode = 1'b1;
         if (pins.io_out == 8'h00) status_mode = 1'b0;
         cmd = pins.io_out;
         addr_q.delete();
      end else if (!pins.ce_n && pins.ale) begin
         addr_q.push_back(pins.io_out);
         if (cmd == 8'h78 && addr_q.size() == 3) begin
            sel_die = addr_q[2][0];
            status_mode = 1'b1;
         end
         if (cmd == 8'h85 && addr_q.size() == 2) begin
            col = {addr_q[1], addr_q[0]};
            status_mode = 1'b0;
         end
         if (cmd == 8'h85 && addr_q.size() == 5) dest_row = {addr_q[4], addr_q[3], addr_q[2]};
      end else if (!pins.ce_n) begin
         cache[col % 4352] = pins.io_out;
         col++;
      end
   end
   always @(posedge pins.re_n) begin
      if (!pins.ce_n) begin
         last = status_mode ? stat : cache[col % 4352];
         if (!status_mode) col++;
      end
   end
endmodule

// *** testbench.sv ***
// self-checking bench for the nand status and column host controller
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] ST0 = 8'hE0;
   localparam logic [7:0] ST1 = 8'hC1;
   logic                 core_clk;
   logic                 reset;
   logic                 req_valid;
   logic                 req_ready;
   nand_host_pkg::req_t  req;
   logic                 power_on_reset_busy;
   logic                 otp_mode;
   logic                 multi_die_active;
   logic                 refused;
   logic                 rsp_valid;
   logic [7:0]           rsp_data;
   nand_host_pkg::pins_t pins;
   logic [7:0]           io_in;
   logic                 seen_refused;
   int                   failures;
   int                   samples_checked;
   int                   seed;
   int                   c;
   int                   d;
   int                   exp_cache [int];
   nand_status_column_cmds #(.STROBE_CYCLES(1)) u_nand_status_column_cmds (
      .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .power_on_reset_busy(power_on_reset_busy), .otp_mode(otp_mode),
      .multi_die_active(multi_die_active), .refused(refused), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .pins(pins), .io_in(io_in));
   nand_die_model #(.STATUS_DIE0(ST0), .STATUS_DIE1(ST1)) u_nand_die_model (
      .pins(pins), .io_in(io_in));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [7:0] exp_byte(input int a);
      return exp_cache.exists(a) ? exp_cache[a][7:0] : (8'(a) ^ 8'h3C);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] expected);
      samples_checked++;
      if (seen !== expected) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(input nand_host_pkg::op_t op, input int col, input int row, input int wd);
      int n;
      req_valid <= 1'b1;
      req <= '{op, 16'(col), 24'(row), 8'(wd)};
      @(posedge core_clk);
      while (!req_ready) @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      #1;
      while (!rsp_valid && !refused && n < 300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      seen_refused = refused;
      if (n >= 300) failures++;
      @(posedge core_clk);
   endtask
   initial begin
      #200000;
      failures++;
      wrap_up();
   end
   initial begin
      seed = 32'h5074;
      failures = 0;
      samples_checked = 0;
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      {power_on_reset_busy, otp_mode, multi_die_active} = 3'b000;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      run(nand_host_pkg::OP_ADDR_STATUS, 0, 24'h010000, 0);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, ST1);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, ST1);
      run(nand_host_pkg::OP_STATUS, 0, 0, 0);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, ST1);
      run(nand_host_pkg::OP_ADDR_STATUS, 0, 24'h000000, 0);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, ST0);
      run(nand_host_pkg::OP_READ_MODE, 0, 0, 0);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, exp_byte(0));
      for (int i = 0; i < 4; i++) begin
         c = (i == 0) ? 4351 : $unsigned($random(seed)) % 4352;
         d = $random(seed) & 8'hFF;
         run(nand_host_pkg::OP_RAND_IN, c, 0, 0);
         run(nand_host_pkg::OP_WRITE_BYTE, 0, 0, d);
         run(nand_host_pkg::OP_WRITE_BYTE, 0, 0, d ^ 8'h5A);
         exp_cache[c] = d;
         exp_cache[(c + 1) % 4352] = d ^ 8'h5A;
         run(nand_host_pkg::OP_RAND_OUT, c, 0, 0);
         run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
         check(rsp_data, exp_byte(c));
         run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
         check(rsp_data, exp_byte((c + 1) % 4352));
      end
      d = $random(seed) & 16'hFFFF;
      run(nand_host_pkg::OP_REDIRECT, 16'h0010, d, 0);
      check(u_nand_die_model.dest_row[7:0], 8'(d));
      check(u_nand_die_model.dest_row[15:8], 8'(d >> 8));
      check(u_nand_die_model.dest_row[23:16], 8'h00);
      for (int k = 0; k < 3; k++) begin
         {power_on_reset_busy, otp_mode, multi_die_active} <= 3'b100 >> k;
         run((k == 2) ? nand_host_pkg::OP_STATUS : nand_host_pkg::OP_ADDR_STATUS, 0, 0, 0);
         check({7'h00, seen_refused}, 8'h01);
      end
      run(nand_host_pkg::OP_RAND_OUT, 16'h0005, 0, 0);
      check({7'h00, seen_refused}, 8'h01);
      run(nand_host_pkg::OP_ADDR_STATUS, 0, 24'h010000, 0);
      check({7'h00, seen_refused}, 8'h00);
      run(nand_host_pkg::OP_RAND_OUT, 16'h0005, 0, 0);
      check({7'h00, seen_refused}, 8'h00);
      run(nand_host_pkg::OP_READ_BYTE, 0, 0, 0);
      check(rsp_data, exp_byte(5));
      wrap_up();
   end
endmodule
